// file: include/adc_monitor_defs.vh
// Offsets, field positions, reset values and sizes for the converter result monitor block
`ifndef ADC_MONITOR_DEFS_VH
`define ADC_MONITOR_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define ADDR_W 8
`define OFS_MONITOR0_CONTROL 8'h00
`define OFS_MONITOR1_CONTROL 8'h04
`define OFS_RESULT_BASE 8'h08
`define RESULT_WORD_BASE 6'h02

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define MON_ENABLE_BIT 0
`define MON_TARGET_LSB 1
`define MON_TARGET_MSB 4
`define MON_DIRECTION_BIT 5
`define MON_SPARE_BIT 7
`define MON0_CTRL_MASK 8'hBF
`define MON1_CTRL_MASK 8'h3F
`define MON_CTRL_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
// Result register fields
`define RES_VALUE_LSB 6
`define RES_VALUE_MSB 15
`define RES_OVERRUN_BIT 1
`define RES_STORED_BIT 0
`define RES_VALUE_RESET 10'h000

////////////////////////////////////////////////////////////////////////////////
// Sizes
`define NUM_NORMAL_RESULTS 8
`define NUM_RESULTS 9
`define TOP_PRIORITY_INDEX 4'h8
`define NUM_MONITORS 2
`define RESULT_BITS 10

`endif

// file: sim/adc_monitor_chk.sv
// Assertions on the result monitor block pins
`timescale 1ns/100ps
`include "adc_monitor_defs.vh"
module adc_monitor_chk #(parameter RES_W = 10) (
  input logic core_clk,
  input logic nrst,
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  input logic res_store,
  input logic [3:0] res_index,
  input logic [RES_W-1:0] res_value,
  input logic [RES_W-1:0] cmp0_value,
  input logic [RES_W-1:0] cmp1_value,
  input logic monitor0_irq,
  input logic monitor1_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] c0_r, c1_r;
  logic hit0, hit1;
  // Shadow control bytes, since only the pins are visible here
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h00) c0_r <= reg_wdata[7:0];
      if (reg_addr == 8'h04) c1_r <= reg_wdata[7:0];
    end
  end
  assign hit0 = res_store && c0_r[0] && res_index == (c0_r[4] ? 4'h8 : {1'b0, c0_r[3:1]})
    && (c0_r[5] ? res_value > cmp0_value : res_value < cmp0_value);
  assign hit1 = res_store && c1_r[0] && res_index == (c1_r[4] ? 4'h8 : {1'b0, c1_r[3:1]})
    && (c1_r[5] ? res_value > cmp1_value : res_value < cmp1_value);
  a_irq0_hit: assert property (hit0 |=> monitor0_irq)
    else $error("monitor0 interrupt missing");
  a_irq0_quiet: assert property (!hit0 |=> !monitor0_irq)
    else $error("monitor0 interrupt unexpected");
  a_irq1_hit: assert property (hit1 |=> monitor1_irq)
    else $error("monitor1 interrupt missing");
  a_irq1_quiet: assert property (!hit1 |=> !monitor1_irq)
    else $error("monitor1 interrupt unexpected");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero when idle");
  a_upper_zero: assert property (reg_rd |=> reg_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_ctrl0_back: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == {24'h0, c0_r & `MON0_CTRL_MASK})
    else $error("monitor0 control readback wrong");
  a_ctrl1_back: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == {24'h0, c1_r & `MON1_CTRL_MASK})
    else $error("monitor1 control readback wrong");
  a_flags_clear: assert property ((reg_rd && reg_addr == 8'h08 && !res_store ##1 !res_store [*2] ##0
    reg_rd && reg_addr == 8'h08) |=> reg_rdata[1:0] == 2'b00)
    else $error("result flags not cleared by read");
endmodule
bind adc_result_monitor_config adc_monitor_chk #(.RES_W(RES_W)) adc_monitor_chk_inst (.core_clk(core_clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .res_store(res_store), .res_index(res_index), .res_value(res_value),
  .cmp0_value(cmp0_value), .cmp1_value(cmp1_value), .monitor0_irq(monitor0_irq), .monitor1_irq(monitor1_irq));

// file: sim/adc_result_monitor_config_test.sv
// Self-checking bench for the result monitor block
`timescale 1ns/100ps
module adc_result_monitor_config_test;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic res_store = 1'b0;
  logic [3:0] res_index = 4'h0;
  logic [9:0] res_value = 10'h000;
  logic [9:0] cmp0_value = 10'h100;
  logic [9:0] cmp1_value = 10'h0FF;
  wire [31:0] reg_rdata;
  wire monitor0_irq, monitor1_irq;
  int err_count = 0;
  int compares = 0;
  adc_result_monitor_config adc_result_monitor_config_inst (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .res_store(res_store), .res_index(res_index), .res_value(res_value), .cmp0_value(cmp0_value),
    .cmp1_value(cmp1_value), .monitor0_irq(monitor0_irq), .monitor1_irq(monitor1_irq));
  initial forever #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  task chk_irq(input logic [1:0] e);
    compares++;
    if ({monitor1_irq, monitor0_irq} !== e) begin
      err_count++;
      $display("ERROR irq expected %b seen %b", e, {monitor1_irq, monitor0_irq});
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand one cycle only, so look just after the taking edge
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task st(input logic [3:0] i, input logic [9:0] v, input logic [1:0] e);
    @(posedge core_clk);
    res_store <= 1'b1;
    res_index <= i;
    res_value <= v;
    @(posedge core_clk);
    res_store <= 1'b0;
    #1;
    chk_irq(e);
  endtask
  function logic hit(input logic [7:0] c, input logic [9:0] k, input logic [3:0] i, input logic [9:0] v);
    hit = c[0] && i == (c[4] ? 4'h8 : {1'b0, c[3:1]}) && (c[5] ? v > k : v < k);
  endfunction
  // Index 8 is written as both 1000 and 1111, the two ends of the 1xxx group
  function logic [3:0] tc(input int n, input int d);
    tc = (n == 8) ? (d ? 4'h8 : 4'hF) : n[3:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(8'h00, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h000000BF);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h0000003F);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h0);
  endtask
  task t_mon;
    logic [7:0] c0, c1;
    logic [9:0] v;
    for (int t = 0; t < 9; t++) begin
      for (int d = 0; d < 2; d++) begin
        c0 = {2'b00, d[0], tc(t, d), 1'b1};
        c1 = {2'b00, ~d[0], tc(8 - t, d), t != 3};
        wr(8'h00, {24'h0, c0});
        wr(8'h04, {24'h0, c1});
        for (int n = 0; n < 3; n++) begin
          v = (n == 0) ? 10'h005 : (n == 1) ? 10'h100 : 10'h3FF;
          st(t, v, {hit(c1, cmp1_value, t, v), hit(c0, cmp0_value, t, v)});
          st(8 - t, v, {hit(c1, cmp1_value, 8 - t, v), hit(c0, cmp0_value, 8 - t, v)});
          st(4'h9, v, 2'b00);
        end
      end
    end
  endtask
  task t_res;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    st(4'h0, 10'h001, 2'b00);
    rd(8'h08, {16'h0, 10'h001, 6'h03});
    rd(8'h08, {16'h0, 10'h001, 6'h00});
    rd(8'h10, {16'h0, 10'h3FF, 6'h03});
    st(4'h2, 10'h2A5, 2'b00);
    rd(8'h10, {16'h0, 10'h2A5, 6'h01});
    st(4'h2, 10'h155, 2'b00);
    st(4'h2, 10'h0AA, 2'b00);
    rd(8'h10, {16'h0, 10'h0AA, 6'h03});
    st(4'h8, 10'h200, 2'b00);
    rd(8'h28, {16'h0, 10'h200, 6'h03});
  endtask
  // A reset in mid-run must drop control and result words back to zero
  task t_rst;
    wr(8'h00, 32'h0000003F);
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h28, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs;
    t_mon;
    t_res;
    t_rst;
    give_verdict;
  end
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
endmodule

// file: src/adc_result_monitor_config.v
// Two result monitors with their control registers and the nine result registers
//
// What this block does
// RULE1: Monitor zero enable bit 0 gates comparison
// RULE2: Monitor one enable bit 0 gates comparison
// RULE3: Monitor zero bit 5: below or above
// RULE4: Monitor one bit 5: below or above
// RULE5: Monitor zero target: 0-7 normal, 1xxx top
// RULE6: Monitor one target decoded the same way
// RULE7: Result in bits 15-6, stored flag bit 0
// RULE8: Overrun bit 1 on unread overwrite, read-cleared
// RULE9: New stored target result compared, interrupt raised
`timescale 1ns/100ps

`include "adc_monitor_defs.vh"

module adc_result_monitor_config #(
  parameter RES_W = `RESULT_BITS,
  parameter NRES = `NUM_RESULTS
) (
  core_clk,
  nrst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  res_store,
  res_index,
  res_value,
  cmp0_value,
  cmp1_value,
  monitor0_irq,
  monitor1_irq
);
  input wire core_clk;
  input wire nrst;
  input wire [`ADDR_W-1:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  input wire res_store;
  input wire [3:0] res_index;
  input wire [RES_W-1:0] res_value;
  input wire [RES_W-1:0] cmp0_value;
  input wire [RES_W-1:0] cmp1_value;
  output reg monitor0_irq;
  output reg monitor1_irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  reg [7:0] monitor0_control_r;
  reg [7:0] monitor1_control_r;
  wire sel_mon0;
  wire sel_mon1;
  wire wr_mon0;
  wire wr_mon1;

  // Full-address match, so misaligned or aliased offsets reach nothing
  assign sel_mon0 = (reg_addr == `OFS_MONITOR0_CONTROL);
  assign sel_mon1 = (reg_addr == `OFS_MONITOR1_CONTROL);
  assign wr_mon0 = reg_wr && sel_mon0;
  assign wr_mon1 = reg_wr && sel_mon1;

  reg [7:0] monitor0_control_nxt;
  reg [7:0] monitor1_control_nxt;

  // Bit 6 of monitor zero and bits 7-6 of monitor one never store anything,
  // so masking on the way in keeps readback and comparison in step
  always @* begin
    monitor0_control_nxt = monitor0_control_r;
    monitor1_control_nxt = monitor1_control_r;
    if (wr_mon0) begin
      monitor0_control_nxt = reg_wdata[7:0] & `MON0_CTRL_MASK; // [RULE1] [RULE3] [RULE5]
    end
    if (wr_mon1) begin
      monitor1_control_nxt = reg_wdata[7:0] & `MON1_CTRL_MASK; // [RULE2] [RULE4] [RULE6]
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      monitor0_control_r <= `MON_CTRL_RESET;
      monitor1_control_r <= `MON_CTRL_RESET;
    end else begin
      monitor0_control_r <= monitor0_control_nxt;
      monitor1_control_r <= monitor1_control_nxt;
    end
  end

  wire monitor0_enable;
  wire monitor1_enable;
  wire monitor0_direction;
  wire monitor1_direction;
  wire [3:0] monitor0_target_select;
  wire [3:0] monitor1_target_select;

  assign monitor0_enable = monitor0_control_r[`MON_ENABLE_BIT];
  assign monitor1_enable = monitor1_control_r[`MON_ENABLE_BIT];
  assign monitor0_direction = monitor0_control_r[`MON_DIRECTION_BIT];
  assign monitor1_direction = monitor1_control_r[`MON_DIRECTION_BIT];
  assign monitor0_target_select = monitor0_control_r[`MON_TARGET_MSB:`MON_TARGET_LSB];
  assign monitor1_target_select = monitor1_control_r[`MON_TARGET_MSB:`MON_TARGET_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Result registers: index 0-7 normal, index 8 top priority
  // Only aligned offsets decode; writes here are ignored, the words are read-only
  wire [5:0] word_idx;
  wire [5:0] slot_sel;
  wire is_result;
  wire [NRES*32-1:0] slot_words;

  assign word_idx = reg_addr[`ADDR_W-1:2];
  assign slot_sel = word_idx - `RESULT_WORD_BASE;
  assign is_result = (reg_addr[1:0] == 2'h0) && (word_idx >= `RESULT_WORD_BASE)
                     && (slot_sel < NRES);

  genvar gi;
  generate
    for (gi = 0; gi < NRES; gi = gi + 1) begin : g_slot
      wire slot_store;
      wire slot_rd;
      assign slot_store = res_store && (res_index == gi);
      // A read of the word with no store to it in the same cycle clears both flags, as software sees them together
      assign slot_rd = reg_rd && is_result && (slot_sel == gi);
      result_slot #(
        .RES_W(RES_W)
      ) result_slot_inst (
        .core_clk(core_clk),
        .nrst(nrst),
        .store(slot_store),
        .value_in(res_value),
        .rd_clr(slot_rd),
        .word(slot_words[gi*32 +: 32])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Target decode: any code with bit 3 set means the top-priority register
  // Codes 1001 to 1111 alias it too, so no code leaves a monitor without a target
  function [3:0] target_index;
    input [3:0] sel;
    begin
      if (sel[3]) begin
        target_index = `TOP_PRIORITY_INDEX;
      end else begin
        target_index = {1'b0, sel[2:0]};
      end
    end
  endfunction

  wire [3:0] mon0_target;
  wire [3:0] mon1_target;
  assign mon0_target = target_index(monitor0_target_select); // [RULE5]
  assign mon1_target = target_index(monitor1_target_select); // [RULE6]

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison on the result being stored this cycle; equal values never fire
  wire [`NUM_MONITORS-1:0] mon_enable;
  wire [`NUM_MONITORS-1:0] mon_direction;
  wire [`NUM_MONITORS*4-1:0] mon_target;
  wire [`NUM_MONITORS*RES_W-1:0] mon_cmp;
  wire [`NUM_MONITORS-1:0] mon_hit;

  assign mon_enable = {monitor1_enable, monitor0_enable}; // [RULE1] [RULE2]
  assign mon_direction = {monitor1_direction, monitor0_direction}; // [RULE3] [RULE4]
  assign mon_target = {mon1_target, mon0_target}; // [RULE5] [RULE6]
  assign mon_cmp = {cmp1_value, cmp0_value};

  // The compare looks at the incoming value, not the stored word, so the
  // interrupt follows the store by exactly one cycle
  genvar gm;
  generate
    for (gm = 0; gm < `NUM_MONITORS; gm = gm + 1) begin : g_mon
      wire [RES_W-1:0] limit;
      wire cond;
      assign limit = mon_cmp[gm*RES_W +: RES_W];
      assign cond = mon_direction[gm] ? (res_value > limit) : (res_value < limit); // [RULE3] [RULE4]
      assign mon_hit[gm] = mon_enable[gm] && res_store && (res_index == mon_target[gm*4 +: 4]) && cond; // [RULE9]
    end
  endgenerate

  // Registered so the interrupt pins never glitch while the compare settles
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      monitor0_irq <= 1'b0;
      monitor1_irq <= 1'b0;
    end else begin
      monitor0_irq <= mon_hit[0]; // [RULE9]
      monitor1_irq <= mon_hit[1]; // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped addresses read zero
  // Zero outside the read cycle, so several slaves can share one OR-ed bus
  reg [31:0] rdata_nxt;
  wire [3:0] rd_slot;

  assign rd_slot = slot_sel[3:0];

  always @* begin
    rdata_nxt = 32'h00000000;
    if (sel_mon0) begin
      rdata_nxt = {24'h000000, monitor0_control_r};
    end else if (sel_mon1) begin
      rdata_nxt = {24'h000000, monitor1_control_r};
    end else if (is_result) begin
      rdata_nxt = slot_words[rd_slot*32 +: 32];
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// file: src/result_slot.v
// One conversion result register with stored and overrun flags
`timescale 1ns/100ps

`include "adc_monitor_defs.vh"

module result_slot #(
  parameter RES_W = `RESULT_BITS
) (
  core_clk,
  nrst,
  store,
  value_in,
  rd_clr,
  word
);
  input wire core_clk;
  input wire nrst;
  input wire store;
  input wire [RES_W-1:0] value_in;
  input wire rd_clr;
  output wire [31:0] word;

  reg [RES_W-1:0] value_r;
  reg stored_r;
  reg overrun_r;

  ////////////////////////////////////////////////////////////////////////////////
  // A store in the same cycle as a read wins for the stored flag, so no result goes unflagged
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      value_r <= `RES_VALUE_RESET;
      stored_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      if (store) begin
        value_r <= value_in; // [RULE7]
      end
      if (store) begin
        stored_r <= 1'b1; // [RULE7]
      end else if (rd_clr) begin
        stored_r <= 1'b0; // [RULE7]
      end
      if (store && stored_r && !rd_clr) begin
        overrun_r <= 1'b1; // [RULE8]
      end else if (rd_clr) begin
        overrun_r <= 1'b0; // [RULE8]
      end
    end
  end

  assign word = {16'h0000, value_r, 4'h0, overrun_r, stored_r}; // [RULE7] [RULE8]

endmodule
